/* File: hw/audio_converter_verb_regs.sv */
`timescale 1ns/10ps
module audio_converter_verb_regs #(
    parameter int SETTLE_CYCLES = audio_conv_pkg::PS_SETTLE_CYCLES
) (
    input  wire logic                      mclk,
    input  wire logic                      nrst,
    input  wire logic                      verb_valid,
    input  wire audio_conv_pkg::verb_req_t verb_req,
    output logic                           resp_valid,
    output logic [31:0]                    resp_data,
    output audio_conv_pkg::conv_ctrl1_t    conv_ctrl,
    output logic [6:0]                     category_code,
    output logic [3:0]                     coding_type,
    output logic                           link_hold_active,
    output logic [3:0]                     link_stream_number,
    output logic [3:0]                     first_channel,
    output logic [3:0]                     channel_count,
    output logic [1:0]                     actual_state
);

    audio_conv_pkg::verb_cmd_t   cmd;
    audio_conv_pkg::conv_ctrl1_t conv1_reg;
    logic [7:0]                  stream_reg;
    logic [6:0]                  category_reg;
    logic                        hold_reg;
    logic [3:0]                  coding_reg;
    logic [3:0]                  chcount_reg;
    logic                        resp_valid_reg;
    logic [31:0]                 resp_data_reg;
    logic [31:0]                 resp_data_next;
    logic [1:0]                  requested_state;
    logic [1:0]                  ps_actual;

    verb_decoder u_decoder (
        .req (verb_req),
        .cmd (cmd)
    );

    wire [7:0] payload = verb_req.payload;
    wire       do_cmd  = verb_valid;

    wire set_power  = do_cmd && (cmd == audio_conv_pkg::CMD_SET_POWER);
    wire set_stream = do_cmd && (cmd == audio_conv_pkg::CMD_SET_STREAM);
    wire set_conv1  = do_cmd && (cmd == audio_conv_pkg::CMD_SET_CONV1);
    wire set_conv2  = do_cmd && (cmd == audio_conv_pkg::CMD_SET_CONV2);
    wire set_conv3  = do_cmd && (cmd == audio_conv_pkg::CMD_SET_CONV3);
    wire set_chcnt  = do_cmd && (cmd == audio_conv_pkg::CMD_SET_CHCNT);

    power_state_tracker #(
        .SETTLE_CYCLES (SETTLE_CYCLES)
    ) u_power (
        .mclk            (mclk),
        .nrst            (nrst),
        .set_valid       (set_power),
        .set_state       (payload[1:0]),
        .requested_state (requested_state),
        .actual_state    (ps_actual)
    );

    // answer words; fault, clock-halt and settings-reset bits stay zero
    wire [31:0] power_word = {
        21'h00_0000,
        1'b0,
        1'b0,
        1'b0,
        2'h0,
        ps_actual,
        2'h0,
        requested_state
    };

    wire [31:0] conv_word = {
        8'h00,
        hold_reg,
        3'h0,
        coding_reg,
        1'b0,
        category_reg,
        conv1_reg
    };

    wire caps_hit = (payload == audio_conv_pkg::PARAM_POWER_CAPS);
    // unknown parameters and verbs answer zero so the host never stalls
    wire [31:0] param_word = caps_hit ? audio_conv_pkg::POWER_CAPS_VALUE : 32'h0000_0000;

    always_comb begin
        resp_data_next = 32'h0000_0000;
        unique case (cmd)
            audio_conv_pkg::CMD_GET_PARAM:  resp_data_next = param_word;
            audio_conv_pkg::CMD_GET_POWER:  resp_data_next = power_word;
            audio_conv_pkg::CMD_GET_STREAM: resp_data_next = {24'h00_0000, stream_reg};
            audio_conv_pkg::CMD_GET_CONV:   resp_data_next = conv_word;
            audio_conv_pkg::CMD_GET_CHCNT:  resp_data_next = {28'h000_0000, chcount_reg};
            default:                        resp_data_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            resp_valid_reg <= 1'b0;
            resp_data_reg  <= 32'h0000_0000;
        end else begin
            resp_valid_reg <= do_cmd;
            resp_data_reg  <= do_cmd ? resp_data_next : 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            stream_reg <= audio_conv_pkg::STREAM_RESET;
        end else if (set_stream) begin
            stream_reg <= payload;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            conv1_reg <= audio_conv_pkg::CONV1_RESET;
        end else if (set_conv1) begin
            conv1_reg <= payload;
        end
    end

    // byte two bit 7, byte three bits 6:4 and byte four are dropped here
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            category_reg <= audio_conv_pkg::CATEGORY_RESET;
        end else if (set_conv2) begin
            category_reg <= payload[6:0];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hold_reg   <= audio_conv_pkg::HOLD_RESET;
            coding_reg <= audio_conv_pkg::CODING_RESET;
        end else if (set_conv3) begin
            hold_reg   <= payload[7];
            coding_reg <= payload[3:0];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            chcount_reg <= audio_conv_pkg::CHCOUNT_RESET;
        end else if (set_chcnt) begin
            chcount_reg <= payload[3:0];
        end
    end

    assign resp_valid         = resp_valid_reg;
    assign resp_data          = resp_data_reg;
    assign conv_ctrl          = conv1_reg;
    assign category_code      = category_reg;
    assign coding_type        = coding_reg;
    assign link_hold_active   = hold_reg;
    assign link_stream_number = stream_reg[7:4];
    assign first_channel      = stream_reg[3:0];
    assign channel_count      = chcount_reg;
    assign actual_state       = ps_actual;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    wire get_power  = verb_valid && (cmd == audio_conv_pkg::CMD_GET_POWER);
    wire get_stream = verb_valid && (cmd == audio_conv_pkg::CMD_GET_STREAM);
    wire get_conv   = verb_valid && (cmd == audio_conv_pkg::CMD_GET_CONV);
    wire get_chcnt  = verb_valid && (cmd == audio_conv_pkg::CMD_GET_CHCNT);
    wire get_caps   = verb_valid && (cmd == audio_conv_pkg::CMD_GET_PARAM) && caps_hit;
    wire set_conv4  = verb_valid && (cmd == audio_conv_pkg::CMD_SET_CONV4);
    wire any_set    = set_power || set_stream || set_conv1 || set_conv2 || set_conv3
                      || set_conv4 || set_chcnt;

    sequence s_set_power_then_get;
        set_power ##1 get_power;
    endsequence

    sequence s_set_stream_then_get;
        set_stream ##1 get_stream;
    endsequence

    // eight quiet cycles cover the default settle count with room to spare
    sequence s_power_quiet;
        (!set_power)[*8];
    endsequence

    property p_caps_word;
        get_caps |-> ##1 (resp_valid && resp_data == 32'h8000_0009);
    endproperty
    a_caps_word: assert property (p_caps_word)
        else $error("power caps word wrong");

    property p_power_echo;
        s_set_power_then_get |-> ##1 (resp_valid && resp_data[1:0] == $past(payload[1:0], 2));
    endproperty
    a_power_echo: assert property (p_power_echo)
        else $error("power echo mismatch");

    property p_actual_reaches;
        (set_power && payload[1:0] == 2'h0) ##1 (!set_power)[*8] |-> actual_state == 2'h0;
    endproperty
    a_actual_reaches: assert property (p_actual_reaches)
        else $error("actual state stuck");

    property p_actual_reported;
        get_power |-> ##1 resp_data[5:4] == $past(ps_actual);
    endproperty
    a_actual_reported: assert property (p_actual_reported)
        else $error("actual not reported");

    property p_power_zero_bits;
        get_power |-> ##1 (resp_data[10:6] == 5'h00 && resp_data[31:11] == 21'h00_0000);
    endproperty
    a_power_zero_bits: assert property (p_power_zero_bits)
        else $error("power zero bits set");

    property p_stream_outputs;
        set_stream |=> (link_stream_number == $past(payload[7:4])
                        && first_channel == $past(payload[3:0]));
    endproperty
    a_stream_outputs: assert property (p_stream_outputs)
        else $error("stream not taken");

    property p_stream_readback;
        s_set_stream_then_get |-> ##1 resp_data == {24'h00_0000, $past(payload, 2)};
    endproperty
    a_stream_readback: assert property (p_stream_readback)
        else $error("stream readback");

    property p_conv1_take;
        set_conv1 |=> conv_ctrl == $past(payload);
    endproperty
    a_conv1_take: assert property (p_conv1_take)
        else $error("control byte one lost");

    property p_conv_report;
        get_conv |-> ##1 (resp_data[7:0] == $past(conv_ctrl)
                          && resp_data[23] == $past(link_hold_active)
                          && resp_data[19:16] == $past(coding_type)
                          && resp_data[14:8] == $past(category_code));
    endproperty
    a_conv_report: assert property (p_conv_report)
        else $error("converter report wrong");

    property p_category_take;
        set_conv2 |=> category_code == $past(payload[6:0]);
    endproperty
    a_category_take: assert property (p_category_take)
        else $error("category not taken");

    property p_conv3_take;
        set_conv3 |=> (link_hold_active == $past(payload[7])
                       && coding_type == $past(payload[3:0]));
    endproperty
    a_conv3_take: assert property (p_conv3_take)
        else $error("control byte three lost");

    property p_chcount;
        set_chcnt ##1 get_chcnt |-> ##1 resp_data == {28'h000_0000, $past(payload[3:0], 2)};
    endproperty
    a_chcount: assert property (p_chcount)
        else $error("channel count readback");

    property p_conv4_inert;
        set_conv4 |=> ($stable(conv_ctrl) && $stable(category_code)
                       && $stable(coding_type) && $stable(link_hold_active));
    endproperty
    a_conv4_inert: assert property (p_conv4_inert)
        else $error("control byte four acted");

    property p_reserved_zero;
        get_conv |-> ##1 (resp_data[31:24] == 8'h00 && resp_data[22:20] == 3'h0
                          && resp_data[15] == 1'b0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit set");

    property p_one_answer;
        verb_valid |-> ##1 resp_valid;
    endproperty
    a_one_answer: assert property (p_one_answer)
        else $error("verb not answered");

    property p_actual_sleeps;
        (set_power && payload[1:0] == 2'h3) ##1 s_power_quiet |-> actual_state == 2'h3;
    endproperty
    a_actual_sleeps: assert property (p_actual_sleeps)
        else $error("actual state not asleep");

    property p_chcount_take;
        set_chcnt |=> channel_count == $past(payload[3:0]);
    endproperty
    a_chcount_take: assert property (p_chcount_take)
        else $error("channel count not taken");

    property p_count_hold;
        !set_chcnt |=> $stable(channel_count);
    endproperty
    a_count_hold: assert property (p_count_hold)
        else $error("channel count moved");

    // other verbs must leave the stream fields alone
    property p_stream_hold;
        !set_stream |=> ($stable(link_stream_number) && $stable(first_channel));
    endproperty
    a_stream_hold: assert property (p_stream_hold)
        else $error("stream fields moved");

    property p_ctrl_hold;
        !set_conv1 |=> $stable(conv_ctrl);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold)
        else $error("control byte one moved");

    // idle words stay clean so a host sampling every cycle never sees junk
    property p_idle_quiet;
        !verb_valid |=> (!resp_valid && resp_data == 32'h0000_0000);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("answer outside a verb");

    property p_set_answer_zero;
        any_set |=> (resp_valid && resp_data == 32'h0000_0000);
    endproperty
    a_set_answer_zero: assert property (p_set_answer_zero)
        else $error("set verb answered data");

endmodule // audio_converter_verb_regs

/* File: common/audio_conv_pkg.sv */
package audio_conv_pkg;

    // verb identifiers seen on the codec link
    localparam logic [11:0] VERB_GET_PARAM    = 12'hF00;
    localparam logic [11:0] VERB_SET_POWER    = 12'h705;
    localparam logic [11:0] VERB_GET_POWER    = 12'hF05;
    localparam logic [11:0] VERB_SET_STREAM   = 12'h706;
    localparam logic [11:0] VERB_GET_STREAM   = 12'hF06;
    localparam logic [11:0] VERB_GET_CONV     = 12'hF0D;
    localparam logic [11:0] VERB_SET_CONV1    = 12'h70D;
    localparam logic [11:0] VERB_SET_CONV2    = 12'h70E;
    localparam logic [11:0] VERB_SET_CONV3    = 12'h73E;
    localparam logic [11:0] VERB_SET_CONV4    = 12'h73F;
    localparam logic [11:0] VERB_SET_CHCOUNT  = 12'h72D;
    localparam logic [11:0] VERB_GET_CHCOUNT  = 12'hF2D;

    localparam logic [7:0]  PARAM_POWER_CAPS  = 8'h0F;
    localparam logic [31:0] POWER_CAPS_VALUE  = 32'h8000_0009;

    // power state field positions and codes
    localparam int          PS_ACTUAL_LSB     = 4;
    localparam int          PS_FAULT_BIT      = 8;
    localparam int          PS_CLOCK_HALT_BIT = 9;
    localparam int          PS_SETTINGS_BIT   = 10;
    localparam logic [1:0]  PS_FULL_ON        = 2'h0;
    localparam logic [1:0]  PS_DEEP_SLEEP     = 2'h3;
    localparam logic [1:0]  PS_RESET         = 2'h3;

    // converter report field positions
    localparam int          CONV_HOLD_BIT     = 23;
    localparam int          CONV_CODING_LSB   = 16;
    localparam int          CONV_CATEGORY_LSB = 8;

    // reset values
    localparam logic [7:0]  STREAM_RESET      = 8'h00;
    localparam logic [7:0]  CONV1_RESET       = 8'h01;
    localparam logic [6:0]  CATEGORY_RESET    = 7'h00;
    localparam logic        HOLD_RESET        = 1'b1;
    localparam logic [3:0]  CODING_RESET      = 4'h0;
    localparam logic [3:0]  CHCOUNT_RESET     = 4'h0;

    // time for the node to settle into a new power state
    localparam int          CLK_PERIOD_NS     = 50;
    localparam int          PS_SETTLE_NS      = 100;
    localparam int          PS_SETTLE_CYCLES  =
        (PS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        CMD_NONE       = 4'h0,
        CMD_GET_PARAM  = 4'h1,
        CMD_SET_POWER  = 4'h2,
        CMD_GET_POWER  = 4'h3,
        CMD_SET_STREAM = 4'h4,
        CMD_GET_STREAM = 4'h5,
        CMD_GET_CONV   = 4'h6,
        CMD_SET_CONV1  = 4'h7,
        CMD_SET_CONV2  = 4'h8,
        CMD_SET_CONV3  = 4'h9,
        CMD_SET_CONV4  = 4'hA,
        CMD_SET_CHCNT  = 4'hB,
        CMD_GET_CHCNT  = 4'hC
    } verb_cmd_t;

    typedef struct packed {
        logic [11:0] id;
        logic [7:0]  payload;
    } verb_req_t;

    typedef struct packed {
        logic generation_level;
        logic studio_use_flag;
        logic non_pcm;
        logic copyright;
        logic pre_emphasis;
        logic idle_tx_policy;
        logic validity;
        logic digital_content_enable;
    } conv_ctrl1_t;

endpackage

/* File: hw/verb_decoder.sv */
`timescale 1ns/10ps
module verb_decoder (
    input  wire audio_conv_pkg::verb_req_t req,
    output wire audio_conv_pkg::verb_cmd_t cmd
);

    wire [11:0] id = req.id;

    assign cmd =
        (id == audio_conv_pkg::VERB_GET_PARAM)   ? audio_conv_pkg::CMD_GET_PARAM  :
        (id == audio_conv_pkg::VERB_SET_POWER)   ? audio_conv_pkg::CMD_SET_POWER  :
        (id == audio_conv_pkg::VERB_GET_POWER)   ? audio_conv_pkg::CMD_GET_POWER  :
        (id == audio_conv_pkg::VERB_SET_STREAM)  ? audio_conv_pkg::CMD_SET_STREAM :
        (id == audio_conv_pkg::VERB_GET_STREAM)  ? audio_conv_pkg::CMD_GET_STREAM :
        (id == audio_conv_pkg::VERB_GET_CONV)    ? audio_conv_pkg::CMD_GET_CONV   :
        (id == audio_conv_pkg::VERB_SET_CONV1)   ? audio_conv_pkg::CMD_SET_CONV1  :
        (id == audio_conv_pkg::VERB_SET_CONV2)   ? audio_conv_pkg::CMD_SET_CONV2  :
        (id == audio_conv_pkg::VERB_SET_CONV3)   ? audio_conv_pkg::CMD_SET_CONV3  :
        (id == audio_conv_pkg::VERB_SET_CONV4)   ? audio_conv_pkg::CMD_SET_CONV4  :
        (id == audio_conv_pkg::VERB_SET_CHCOUNT) ? audio_conv_pkg::CMD_SET_CHCNT  :
        (id == audio_conv_pkg::VERB_GET_CHCOUNT) ? audio_conv_pkg::CMD_GET_CHCNT  :
                                                   audio_conv_pkg::CMD_NONE;

endmodule // verb_decoder

/* File: hw/power_state_tracker.sv */
`timescale 1ns/10ps
module power_state_tracker #(
    parameter int SETTLE_CYCLES = audio_conv_pkg::PS_SETTLE_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       set_valid,
    input  wire logic [1:0] set_state,
    output logic      [1:0] requested_state,
    output logic      [1:0] actual_state
);

    localparam int CW = $clog2(SETTLE_CYCLES + 1);

    logic [1:0]    requested_reg;
    logic [1:0]    actual_reg;
    logic [CW-1:0] settle_reg;
    logic [1:0]    target_reg;

    // only the two supported codes move the node; others are only echoed
    wire legal_target = (set_state == audio_conv_pkg::PS_FULL_ON) ||
                        (set_state == audio_conv_pkg::PS_DEEP_SLEEP);
    wire settle_done  = (settle_reg == '0);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            requested_reg <= audio_conv_pkg::PS_RESET;
            actual_reg    <= audio_conv_pkg::PS_RESET;
            target_reg    <= audio_conv_pkg::PS_RESET;
            settle_reg    <= '0;
        end else begin
            if (set_valid) begin
                requested_reg <= set_state;
            end
            if (set_valid && legal_target) begin
                target_reg <= set_state;
                settle_reg <= CW'(SETTLE_CYCLES);
            end else if (!settle_done) begin
                settle_reg <= settle_reg - 1'b1;
            end else begin
                actual_reg <= target_reg;
            end
        end
    end

    assign requested_state = requested_reg;
    assign actual_state    = actual_reg;

endmodule // power_state_tracker

/* File: tb/host_verb_model.sv */
`timescale 1ns/10ps
module host_verb_model (
    input  wire logic                      mclk,
    input  wire logic                      nrst,
    input  wire logic                      go,
    input  wire audio_conv_pkg::verb_req_t go_req,
    input  wire logic                      resp_valid,
    input  wire logic [31:0]               resp_data,
    output audio_conv_pkg::verb_req_t      verb_req,
    output logic                           verb_valid,
    output logic                           done,
    output logic [31:0]                    got
);
    // idle request lines toggle so a decoder peeking outside verb_valid shows up
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            verb_valid <= 1'b0;
            verb_req   <= '0;
            done       <= 1'b0;
            got        <= 32'h0000_0000;
        end else begin
            verb_valid <= go;
            verb_req   <= go ? go_req : ~verb_req;
            done       <= resp_valid;
            got        <= resp_valid ? resp_data : ~got;
        end
    end
endmodule // host_verb_model

/* File: tb/audio_converter_verb_regs_tb_top.sv */
`timescale 1ns/10ps
module audio_converter_verb_regs_tb_top;
    localparam int SETTLE = 2;
    logic                        mclk;
    logic                        nrst;
    logic                        go;
    logic                        verb_valid;
    logic                        resp_valid;
    logic                        done;
    logic                        link_hold_active;
    audio_conv_pkg::verb_req_t   go_req;
    audio_conv_pkg::verb_req_t   verb_req;
    audio_conv_pkg::conv_ctrl1_t conv_ctrl;
    logic [31:0]                 resp_data;
    logic [31:0]                 got;
    logic [31:0]                 seen;
    logic [6:0]                  category_code;
    logic [3:0]                  coding_type;
    logic [3:0]                  link_stream_number;
    logic [3:0]                  first_channel;
    logic [3:0]                  channel_count;
    logic [1:0]                  actual_state;
    logic [7:0]                  c1_e;
    logic [6:0]                  cat_e;
    logic [3:0]                  cod_e;
    logic                        hold_e;
    int                          n_errors;
    int                          checks_done;
    int                          cycles;

    audio_converter_verb_regs #(.SETTLE_CYCLES(SETTLE)) u_dut (
        .mclk(mclk), .nrst(nrst), .verb_valid(verb_valid), .verb_req(verb_req),
        .resp_valid(resp_valid), .resp_data(resp_data), .conv_ctrl(conv_ctrl),
        .category_code(category_code), .coding_type(coding_type),
        .link_hold_active(link_hold_active), .link_stream_number(link_stream_number),
        .first_channel(first_channel), .channel_count(channel_count),
        .actual_state(actual_state));

    host_verb_model u_host (
        .mclk(mclk), .nrst(nrst), .go(go), .go_req(go_req), .resp_valid(resp_valid),
        .resp_data(resp_data), .verb_req(verb_req), .verb_valid(verb_valid),
        .done(done), .got(got));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // a hung handshake ends the run instead of stalling it
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            $display("unexpected timeout after %0d cycles", cycles);
            test_done();
        end
    end

    task automatic chk(input string what, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, e, s);
        end
    endtask

    task automatic verb(input logic [11:0] id, input logic [7:0] pl);
        @(posedge mclk);
        go     <= 1'b1;
        go_req <= {id, pl};
        @(posedge mclk);
        go <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            #1;
            if (done === 1'b1) break;
        end
        seen = (done === 1'b1) ? got : 'x;
    endtask

    function automatic logic [31:0] conv_exp();
        return {8'h00, hold_e, 3'h0, cod_e, 1'b0, cat_e, c1_e};
    endfunction

    function automatic logic [31:0] pw_exp(input logic [1:0] req, input logic [1:0] act);
        return {26'h0, act, 2'h0, req};
    endfunction

    task automatic cfg_chk();
        chk("conv_ctrl", {24'h0, conv_ctrl}, {24'h0, c1_e});
        chk("category_code", {25'h0, category_code}, {25'h0, cat_e});
        chk("coding_type", {28'h0, coding_type}, {28'h0, cod_e});
        chk("link_hold_active", {31'h0, link_hold_active}, {31'h0, hold_e});
    endtask

    task automatic reset_chk();
        c1_e   = 8'h01;
        cat_e  = 7'h00;
        cod_e  = 4'h0;
        hold_e = 1'b1;
        @(posedge mclk);
        #1;
        chk("actual_state", {30'h0, actual_state}, 32'h0000_0003);
        chk("stream", {24'h0, link_stream_number, first_channel}, 32'h0);
        chk("channel_count", {28'h0, channel_count}, 32'h0);
        cfg_chk();
        verb(audio_conv_pkg::VERB_GET_POWER, 8'h00);
        chk("power_report", seen, pw_exp(2'h3, 2'h3));
        verb(audio_conv_pkg::VERB_GET_CONV, 8'h00);
        chk("conv_report", seen, conv_exp());
        verb(audio_conv_pkg::VERB_GET_STREAM, 8'h00);
        chk("stream_report", seen, 32'h0);
        verb(audio_conv_pkg::VERB_GET_CHCOUNT, 8'h00);
        chk("count_report", seen, 32'h0);
        $display("test reset ends");
    endtask

    initial begin
        nrst        = 1'b0;
        go          = 1'b0;
        go_req      = '0;
        n_errors    = 0;
        checks_done = 0;
        cycles      = 0;
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        reset_chk();

        verb(audio_conv_pkg::VERB_GET_PARAM, audio_conv_pkg::PARAM_POWER_CAPS);
        chk("power_caps", seen, 32'h8000_0009);
        verb(audio_conv_pkg::VERB_GET_PARAM, 8'h09);
        chk("other_param", seen, 32'h0);
        verb(12'h123, 8'hFF);
        chk("unknown_verb", seen, 32'h0);
        $display("test params ends");

        // host asks only full-on or deep sleep; reserved bits set on purpose
        verb(audio_conv_pkg::VERB_SET_POWER, 8'hFC);
        chk("set_answer", seen, 32'h0);
        repeat (SETTLE + 4) @(posedge mclk);
        verb(audio_conv_pkg::VERB_GET_POWER, 8'h00);
        chk("power_report", seen, pw_exp(2'h0, 2'h0));
        chk("actual_state", {30'h0, actual_state}, 32'h0);
        verb(audio_conv_pkg::VERB_SET_POWER, 8'h03);
        verb(audio_conv_pkg::VERB_GET_POWER, 8'h00);
        chk("requested_echo", {30'h0, seen[1:0]}, 32'h3);
        repeat (SETTLE + 4) @(posedge mclk);
        verb(audio_conv_pkg::VERB_GET_POWER, 8'h00);
        chk("power_report", seen, pw_exp(2'h3, 2'h3));
        $display("test power ends");

        // set and get back to back on adjacent edges
        @(posedge mclk);
        go     <= 1'b1;
        go_req <= {audio_conv_pkg::VERB_SET_STREAM, 8'h52};
        @(posedge mclk);
        go_req <= {audio_conv_pkg::VERB_GET_STREAM, 8'h00};
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
        #1;
        chk("stream", {24'h0, link_stream_number, first_channel}, 32'h52);
        @(posedge mclk);
        #1;
        chk("stream_report", (done === 1'b1) ? got : 'x, 32'h52);
        verb(audio_conv_pkg::VERB_SET_STREAM, 8'hFF);
        verb(audio_conv_pkg::VERB_GET_STREAM, 8'h00);
        chk("stream_report", seen, 32'hFF);
        $display("test stream ends");

        for (int b = 0; b < 8; b++) begin
            c1_e = 8'h01 << b;
            verb(audio_conv_pkg::VERB_SET_CONV1, c1_e);
            cfg_chk();
            verb(audio_conv_pkg::VERB_GET_CONV, 8'h00);
            chk("conv_report", seen, conv_exp());
        end
        verb(audio_conv_pkg::VERB_SET_CONV2, 8'hFF);
        cat_e = 7'h7F;
        verb(audio_conv_pkg::VERB_SET_CONV3, 8'hFF);
        cod_e = 4'hF;
        cfg_chk();
        verb(audio_conv_pkg::VERB_GET_CONV, 8'h00);
        chk("conv_report", seen, conv_exp());
        verb(audio_conv_pkg::VERB_SET_CONV3, 8'h05);
        cod_e  = 4'h5;
        hold_e = 1'b0;
        verb(audio_conv_pkg::VERB_SET_CONV2, 8'h2A);
        cat_e = 7'h2A;
        verb(audio_conv_pkg::VERB_SET_CONV4, 8'hFF);
        chk("set_answer", seen, 32'h0);
        cfg_chk();
        verb(audio_conv_pkg::VERB_GET_CONV, 8'h00);
        chk("conv_report", seen, conv_exp());
        $display("test converter ends");

        verb(audio_conv_pkg::VERB_SET_CHCOUNT, 8'hFF);
        chk("channel_count", {28'h0, channel_count}, 32'hF);
        verb(audio_conv_pkg::VERB_SET_CHCOUNT, 8'h35);
        verb(audio_conv_pkg::VERB_GET_CHCOUNT, 8'h00);
        chk("count_report", seen, 32'h5);
        $display("test count ends");

        // leave state off its reset values so the second reset has work to do
        verb(audio_conv_pkg::VERB_SET_POWER, 8'h00);
        // second reset mid-run must restore every setting
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        reset_chk();
        test_done();
    end
endmodule // audio_converter_verb_regs_tb_top
